// File: drs_pkg.sv
// constants, types and register map of the disk read sequencer
package drs_pkg;

   // clock and timing
   localparam int CLK_MHZ       = 100;
   localparam int SEL_US        = 3;
   localparam int SEL_CYC       = SEL_US * CLK_MHZ + 1;
   localparam int MARK_MS       = 1;
   localparam int MARK_CYC      = MARK_MS * 1000 * CLK_MHZ;
   localparam int HT_UNIT_MS    = 1;
   localparam int HT_UNIT_CYC   = HT_UNIT_MS * 1000 * CLK_MHZ;
   localparam int OVR_FM_LO_US  = 54;
   localparam int OVR_MFM_LO_US = 22;
   localparam int OVR_FM_HI_US  = 27;
   localparam int OVR_MFM_HI_US = 11;
   localparam int OVR_FM_LO_CYC  = OVR_FM_LO_US * CLK_MHZ;
   localparam int OVR_MFM_LO_CYC = OVR_MFM_LO_US * CLK_MHZ;
   localparam int OVR_FM_HI_CYC  = OVR_FM_HI_US * CLK_MHZ;
   localparam int OVR_MFM_HI_CYC = OVR_MFM_HI_US * CLK_MHZ;

   // register byte addresses
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_PARAM  = 8'h04;
   localparam logic [7:0] REG_LIMIT  = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_DATA   = 8'h10;
   localparam logic [7:0] REG_RESULT = 8'h14;

   // control word bits
   localparam int CTRL_START = 0;
   localparam int CTRL_UNIT  = 1;
   localparam int CTRL_HSEL  = 3;
   localparam int CTRL_MT    = 4;
   localparam int CTRL_SKIP  = 5;
   localparam int CTRL_MFM   = 6;
   localparam int CTRL_PIO   = 7;
   // limit word fields
   localparam int LIM_ESN = 0;
   localparam int LIM_MNL = 8;
   localparam int LIM_HLT = 16;
   localparam int LIM_HUT = 24;

   // sector status bit positions
   localparam int SS0_NOT_READY  = 3;
   localparam int SS0_TERM       = 6;
   localparam logic [1:0] TERM_ABNORMAL = 2'h1;
   localparam int SS1_MARK_MISS  = 0;
   localparam int SS1_ID_MISS    = 2;
   localparam int SS1_OVERRUN    = 4;
   localparam int SS1_CRC        = 5;
   localparam int SS1_NO_END     = 7;
   localparam int SS2_DMARK_MISS = 0;
   localparam int SS2_BAD_CYL    = 1;
   localparam int SS2_CYL_MISM   = 4;
   localparam int SS2_DATA_CRC   = 5;
   localparam int SS2_DELETED    = 6;

   // byte values
   localparam logic [7:0] DATA_MARK    = 8'hfb;
   localparam logic [7:0] DELETED_MARK = 8'hf8;
   localparam logic [7:0] BAD_CYL_VAL  = 8'hff;
   localparam logic [7:0] PARTIAL_LIM  = 8'h80;
   localparam logic [7:0] SECTOR_FIRST = 8'h01;
   localparam logic [7:0] FILLER       = 8'h00;

   typedef struct packed {
      logic [7:0] cyl;
      logic [7:0] head;
      logic [7:0] sec;
      logic [7:0] len;
   } drs_id_t;

   // events from the data separator, same clock
   typedef struct packed {
      logic       id_valid;
      logic       id_crc_ok;
      drs_id_t    id;
      logic       mark_valid;
      logic [7:0] mark;
      logic       nonmark;
      logic       byte_valid;
      logic [7:0] data;
      logic       crc_valid;
      logic       crc_ok;
   } drs_disk_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_SEL, ST_LOAD, ST_SEARCH, ST_MARK, ST_DATA, ST_RESULT
   } drs_state_t;

endpackage

// File: drs_read_seq.sv
// read data command sequencer with classic wishbone register slave
// Notes on behaviour
// [RULE_01] select unit and head from parameters when execution starts
// [RULE_02] check ready over 3 us after select and during search; else abort
// [RULE_03] load unloaded heads and wait head load time; skip when loaded
// [RULE_04] no address mark by third index pulse: mark missing, abort
// [RULE_05] mark seen but no matching id by third index: id missing, abort
// [RULE_06] differing ids are crc checked
// [RULE_07] cylinder mismatch: id missing plus bad or mismatch cylinder, abort
// [RULE_08] every id crc checked; id crc error sets crc fail, abort
// [RULE_09] data crc error sets data crc and crc fail, abort
// [RULE_10] no data mark within 1 ms or non-mark after zeros: abort
// [RULE_11] fb is data mark, f8 deleted mark which sets deleted flag
// [RULE_12] deleted: skip clear transfers and ends; skip set moves on
// [RULE_13] each byte requested by dma request or interrupt per io select
// [RULE_14] unread byte within time sets overrun, finish crc, abort
// [RULE_15] no transfer end after last byte: next sector number
// [RULE_16] end sector: multitrack on head 0 goes to head 1, else abort; length 0 with count below 80h goes to next sector instead
// [RULE_17] transfer end mid sector stops requests, rest crc checked
// [RULE_18] transfer end on last byte ends without next sector
// [RULE_19] transfer end within window after request blocks next byte
// [RULE_20] heads stay loaded for unload time; same cylinder skips load
// [RULE_21] length 0 and count below 80h: send count bytes per sector
// [RULE_22] result on transfer end below end sector: sector plus one
// [RULE_23] result at end sector with multitrack: head flip, sector 1
// [RULE_24] final result read loads filler, sets request, clears busy
`timescale 1ns/100ps
`default_nettype none

module drs_read_seq
   import drs_pkg::*;
#(
   parameter int MARK_WAIT_CYC = drs_pkg::MARK_CYC,
   parameter int HT_UNIT       = drs_pkg::HT_UNIT_CYC,
   parameter int OVR_LONG_CYC  = drs_pkg::OVR_FM_LO_CYC
) (
   input  wire logic              i_ref_clk,
   input  wire logic              i_reset,
   input  wire logic              i_wb_cyc,
   input  wire logic              i_wb_stb,
   input  wire logic              i_wb_we,
   input  wire logic [7:0]        i_wb_adr,
   input  wire logic [31:0]       i_wb_dat,
   input  wire logic [3:0]        i_wb_sel,
   output logic      [31:0]       o_wb_dat,
   output logic                   o_wb_ack,
   input  wire drs_pkg::drs_disk_t i_disk,
   input  wire logic              i_index,
   input  wire logic              i_ready,
   input  wire logic              i_drive_size,
   input  wire logic              i_transfer_end,
   output logic      [1:0]        o_unit,
   output logic                   o_head_sel,
   output logic                   o_head_load,
   output logic                   o_dma_req,
   output logic                   o_irq
);
   import drs_pkg::*;

   typedef struct packed {
      drs_state_t  state;
      logic        ack;
      logic [31:0] rdat;
      logic [1:0]  unit;
      logic        hsel;
      logic        mt;
      logic        skip;
      logic        mfm;
      logic        pio;
      drs_id_t     prm;
      drs_id_t     cur;
      drs_id_t     res;
      logic [31:0] lim;
      logic [7:0]  ss0;
      logic [7:0]  ss1;
      logic [7:0]  ss2;
      logic        busy;
      logic        transfer_request_bit;
      logic        dir;
      logic        irq;
      logic        dma_request_output;
      logic [7:0]  dreg;
      logic [16:0] tmr;
      logic [7:0]  hcnt;
      logic [1:0]  idx_cnt;
      logic        seen_am;
      logic        deleted;
      logic        stop;
      logic        ovr;
      logic        pend;
      logic [12:0] otmr;
      logic [14:0] bidx;
      logic        ld;
      logic [1:0]  ld_unit;
      logic [7:0]  ld_cyl;
      logic [1:0]  idx_s;
      logic        idx_q;
      logic [1:0]  rdy_s;
      logic [1:0]  ds_s;
      logic [1:0]  end_s;
   } drs_regs_t;

   drs_regs_t r;
   drs_regs_t next_r;

   logic        bus;
   logic        wr;
   logic        rd;
   logic        idx_rise;
   logic        fin;
   logic        abn;
   logic        skipdel;
   logic [14:0] xlen;
   logic [12:0] olim;
   logic [7:0]  end_sector_number;

   // byte-lane merge for wishbone writes
   function automatic logic [31:0] drs_merge(input logic [31:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  s);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            m[8*b +: 8] = d[8*b +: 8];
         end
      end
      return m;
   endfunction

   // next-state logic for the whole block
   always_comb begin
      next_r   = r;
      bus      = i_wb_cyc & i_wb_stb & ~r.ack;
      wr       = bus & i_wb_we;
      rd       = bus & ~i_wb_we;
      fin      = 1'b0;
      abn      = 1'b0;
      end_sector_number      = r.lim[LIM_ESN +: 8];
      skipdel  = r.deleted & r.skip;
      idx_rise = r.idx_s[1] & ~r.idx_q;
      // partial sector length, else full record length
      if (r.cur.len == 8'h00 && r.lim[LIM_MNL +: 8] < PARTIAL_LIM) begin
         xlen = {7'h00, r.lim[LIM_MNL +: 8]}; // RULE_21
      end else begin
         xlen = 15'(16'h0080 << r.cur.len[2:0]);
      end
      // overrun limit depends on drive size and recording mode
      case ({r.ds_s[1], r.mfm})
         2'b00:   olim = 13'(OVR_LONG_CYC);
         2'b01:   olim = 13'(OVR_MFM_LO_CYC);
         2'b10:   olim = 13'(OVR_FM_HI_CYC);
         default: olim = 13'(OVR_MFM_HI_CYC);
      endcase

      // pin synchronisers; the first stage feeds only the second
      next_r.idx_s = {r.idx_s[0], i_index};
      next_r.idx_q = r.idx_s[1];
      next_r.rdy_s = {r.rdy_s[0], i_ready};
      next_r.ds_s  = {r.ds_s[0], i_drive_size};
      next_r.end_s = {r.end_s[0], i_transfer_end};

      // wishbone: one wait state, every address answered
      next_r.ack = bus;
      if (rd) begin
         case (i_wb_adr)
            REG_CTRL:   next_r.rdat = {24'h0, r.pio, r.mfm, r.skip, r.mt,
                                       r.hsel, r.unit, 1'b0};
            REG_PARAM:  next_r.rdat = r.prm;
            REG_LIMIT:  next_r.rdat = r.lim;
            REG_STATUS: next_r.rdat = {5'h00, r.dir, r.transfer_request_bit, r.busy,
                                       r.ss2, r.ss1, r.ss0};
            REG_DATA:   next_r.rdat = {24'h0, r.dreg};
            REG_RESULT: next_r.rdat = r.res;
            default:    next_r.rdat = 32'h0;
         endcase
      end
      if (wr && !r.busy) begin
         if (i_wb_adr == REG_PARAM) begin
            next_r.prm = drs_id_t'(drs_merge(r.prm, i_wb_dat, i_wb_sel));
         end
         if (i_wb_adr == REG_LIMIT) begin
            next_r.lim = drs_merge(r.lim, i_wb_dat, i_wb_sel);
         end
      end

      case (r.state)
         ST_IDLE, ST_RESULT: begin
            // head unload countdown runs between commands
            if (r.ld) begin
               next_r.tmr = r.tmr + 17'h1;
               if (r.tmr == 17'(HT_UNIT - 1)) begin
                  next_r.tmr = 17'h0;
                  if (r.hcnt == 8'h00) begin
                     next_r.ld = 1'b0; // RULE_20
                  end else begin
                     next_r.hcnt = r.hcnt - 8'h1;
                  end
               end
            end
            if (r.state == ST_RESULT && rd && i_wb_adr == REG_RESULT) begin
               next_r.dreg  = FILLER; // RULE_24
               next_r.transfer_request_bit   = 1'b1;
               next_r.dir   = 1'b0;
               next_r.busy  = 1'b0;
               next_r.irq   = 1'b0;
               next_r.state = ST_IDLE;
            end
            if (r.state == ST_IDLE && wr && i_wb_adr == REG_CTRL &&
                i_wb_sel[0] && i_wb_dat[CTRL_START]) begin
               next_r.unit    = i_wb_dat[CTRL_UNIT +: 2]; // RULE_01
               next_r.hsel    = i_wb_dat[CTRL_HSEL];
               next_r.mt      = i_wb_dat[CTRL_MT];
               next_r.skip    = i_wb_dat[CTRL_SKIP];
               next_r.mfm     = i_wb_dat[CTRL_MFM];
               next_r.pio     = i_wb_dat[CTRL_PIO];
               next_r.cur     = r.prm;
               next_r.res     = r.prm;
               next_r.ss0     = 8'h00;
               next_r.ss1     = 8'h00;
               next_r.ss2     = 8'h00;
               next_r.busy    = 1'b1;
               next_r.transfer_request_bit     = 1'b0;
               next_r.dir     = 1'b0;
               next_r.stop    = 1'b0;
               next_r.ovr     = 1'b0;
               next_r.tmr     = 17'h0;
               next_r.state   = ST_SEL;
            end
         end
         ST_SEL: begin
            // ready only trusted once the select has settled
            next_r.tmr = r.tmr + 17'h1;
            if (r.tmr == 17'(SEL_CYC - 1)) begin
               next_r.tmr = 17'h0;
               if (!r.rdy_s[1]) begin
                  next_r.ss0[SS0_NOT_READY] = 1'b1; // RULE_02
                  fin = 1'b1;
                  abn = 1'b1;
               end else if (r.ld && r.ld_unit == r.unit &&
                            r.ld_cyl == r.cur.cyl) begin
                  next_r.state = ST_SEARCH; // RULE_20
               end else begin
                  next_r.ld      = 1'b1; // RULE_03
                  next_r.ld_unit = r.unit;
                  next_r.ld_cyl  = r.cur.cyl;
                  next_r.hcnt    = r.lim[LIM_HLT +: 8];
                  next_r.state   = ST_LOAD;
               end
               next_r.idx_cnt = 2'h0;
               next_r.seen_am = 1'b0;
            end
         end
         ST_LOAD: begin
            if (r.hcnt == 8'h00) begin
               next_r.tmr   = 17'h0;
               next_r.state = ST_SEARCH; // RULE_03
            end else begin
               next_r.tmr = r.tmr + 17'h1;
               if (r.tmr == 17'(HT_UNIT - 1)) begin
                  next_r.tmr  = 17'h0;
                  next_r.hcnt = r.hcnt - 8'h1;
               end
            end
         end
         ST_SEARCH: begin
            if (!r.rdy_s[1]) begin
               next_r.ss0[SS0_NOT_READY] = 1'b1; // RULE_02
               fin = 1'b1;
               abn = 1'b1;
            end else if (i_disk.id_valid) begin
               next_r.seen_am = 1'b1;
               if (!i_disk.id_crc_ok) begin
                  next_r.ss1[SS1_CRC] = 1'b1; // RULE_06 RULE_08
                  fin = 1'b1;
                  abn = 1'b1;
               end else if (i_disk.id.cyl != r.cur.cyl) begin
                  next_r.ss1[SS1_ID_MISS] = 1'b1; // RULE_07
                  if (r.cur.cyl == BAD_CYL_VAL) begin
                     next_r.ss2[SS2_BAD_CYL] = 1'b1;
                  end else begin
                     next_r.ss2[SS2_CYL_MISM] = 1'b1;
                  end
                  fin = 1'b1;
                  abn = 1'b1;
               end else if (i_disk.id == r.cur) begin
                  next_r.tmr   = 17'h0;
                  next_r.state = ST_MARK;
               end
            end else if (idx_rise) begin
               next_r.idx_cnt = r.idx_cnt + 2'h1;
               if (r.idx_cnt == 2'h2) begin
                  if (r.seen_am) begin
                     next_r.ss1[SS1_ID_MISS] = 1'b1; // RULE_05
                  end else begin
                     next_r.ss1[SS1_MARK_MISS] = 1'b1; // RULE_04
                  end
                  fin = 1'b1;
                  abn = 1'b1;
               end
            end
         end
         ST_MARK: begin
            next_r.tmr = r.tmr + 17'h1;
            next_r.bidx = 15'h0;
            if (i_disk.mark_valid && i_disk.mark == DATA_MARK) begin
               next_r.deleted = 1'b0; // RULE_11
               next_r.state   = ST_DATA;
            end else if (i_disk.mark_valid &&
                         i_disk.mark == DELETED_MARK) begin
               next_r.ss2[SS2_DELETED] = 1'b1; // RULE_11
               next_r.deleted = 1'b1;
               next_r.state   = ST_DATA;
            end else if (i_disk.mark_valid || i_disk.nonmark ||
                         r.tmr == 17'(MARK_WAIT_CYC - 1)) begin
               next_r.ss2[SS2_DMARK_MISS] = 1'b1; // RULE_10
               next_r.ss1[SS1_MARK_MISS]  = 1'b1;
               fin = 1'b1;
               abn = 1'b1;
            end
         end
         ST_DATA: begin
            // host read of the data register retires the request
            if (rd && i_wb_adr == REG_DATA) begin
               next_r.pend = 1'b0;
            end
            if (r.end_s[1] && !r.stop) begin
               next_r.stop = 1'b1; // RULE_17 RULE_19
               next_r.pend = 1'b0;
            end
            // overrun: keep reading so the crc still gets checked
            if (r.pend) begin
               next_r.otmr = r.otmr + 13'h1;
               if (r.otmr == olim - 13'h1) begin
                  next_r.ovr  = 1'b1; // RULE_14
                  next_r.ss1[SS1_OVERRUN] = 1'b1;
                  next_r.pend = 1'b0;
               end
            end
            if (i_disk.byte_valid && !skipdel) begin
               next_r.bidx = r.bidx + 15'h1;
               if (r.bidx < xlen && !next_r.stop && !next_r.ovr) begin
                  next_r.dreg = i_disk.data; // RULE_13
                  next_r.pend = 1'b1;
                  next_r.otmr = 13'h0;
               end
            end
            if (i_disk.crc_valid) begin
               next_r.pend    = 1'b0;
               next_r.tmr     = 17'h0;
               next_r.idx_cnt = 2'h0;
               next_r.seen_am = 1'b0;
               if (!skipdel && !i_disk.crc_ok) begin
                  next_r.ss2[SS2_DATA_CRC] = 1'b1; // RULE_09
                  next_r.ss1[SS1_CRC]      = 1'b1;
                  fin = 1'b1;
                  abn = 1'b1;
               end else if (r.ovr) begin
                  fin = 1'b1; // RULE_14
                  abn = 1'b1;
               end else if (next_r.stop) begin
                  fin = 1'b1; // RULE_17 RULE_18
                  next_r.res.len = r.cur.len;
                  if (r.cur.sec < end_sector_number) begin
                     next_r.res.cyl  = r.cur.cyl; // RULE_22
                     next_r.res.head = r.cur.head;
                     next_r.res.sec  = r.cur.sec + 8'h1;
                  end else if (!r.mt) begin
                     next_r.res.cyl  = r.cur.cyl + 8'h1; // RULE_22
                     next_r.res.head = r.cur.head;
                     next_r.res.sec  = SECTOR_FIRST;
                  end else begin
                     next_r.res.sec = SECTOR_FIRST; // RULE_23
                     if (r.cur.head == 8'h00) begin
                        next_r.res.cyl  = r.cur.cyl;
                        next_r.res.head = 8'h01;
                     end else begin
                        next_r.res.cyl  = r.cur.cyl + 8'h1;
                        next_r.res.head = 8'h00;
                     end
                  end
               end else if (r.deleted && !r.skip) begin
                  fin = 1'b1; // RULE_12
               end else if (r.cur.sec == end_sector_number && xlen != 15'h0 &&
                            !(r.cur.len == 8'h00 &&
                              r.lim[LIM_MNL +: 8] < PARTIAL_LIM)) begin
                  if (r.mt && r.cur.head == 8'h00) begin
                     next_r.cur.sec  = SECTOR_FIRST; // RULE_16
                     next_r.cur.head = 8'h01;
                     next_r.hsel     = 1'b1;
                     next_r.state    = ST_SEARCH;
                  end else begin
                     next_r.ss1[SS1_NO_END] = 1'b1; // RULE_16
                     fin = 1'b1;
                     abn = 1'b1;
                  end
               end else begin
                  next_r.cur.sec = r.cur.sec + 8'h1; // RULE_15 RULE_12
                  next_r.state   = ST_SEARCH;
               end
            end
            next_r.transfer_request_bit  = next_r.pend;
            next_r.dir  = 1'b1;
            next_r.dma_request_output = next_r.pend & ~r.pio; // RULE_13
            next_r.irq  = next_r.pend & r.pio;
         end
         default: begin
            next_r.state = ST_IDLE;
         end
      endcase

      // command end: hand over to result phase and start unload timer
      if (fin) begin
         if (abn) begin
            next_r.ss0[SS0_TERM +: 2] = TERM_ABNORMAL;
            next_r.res = r.cur;
         end else if (!next_r.stop) begin
            next_r.res = r.cur;
         end
         next_r.pend  = 1'b0;
         next_r.dma_request_output  = 1'b0;
         next_r.transfer_request_bit   = 1'b1;
         next_r.dir   = 1'b1;
         next_r.irq   = 1'b1;
         next_r.tmr   = 17'h0;
         next_r.hcnt  = r.lim[LIM_HUT +: 8]; // RULE_20
         next_r.state = ST_RESULT;
      end
   end

   // single state register, synchronous reset
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         r <= '{state: ST_IDLE, default: '0};
      end else begin
         r <= next_r;
      end
   end

   assign o_wb_dat    = r.rdat;
   assign o_wb_ack    = r.ack;
   assign o_unit      = r.unit;
   assign o_head_sel  = r.hsel;
   assign o_head_load = r.ld;
   assign o_dma_req   = r.dma_request_output;
   assign o_irq       = r.irq;

endmodule

`default_nettype wire

// File: drs_read_seq_props.sv
// port assertions for the read data sequencer
`timescale 1ns/100ps
`default_nettype none
module drs_read_seq_props
   import drs_pkg::*;
#(
   parameter int OVR_LONG_CYC = 5400
) (
   input wire logic                i_ref_clk,
   input wire logic                i_reset,
   input wire logic                i_wb_cyc,
   input wire logic                i_wb_stb,
   input wire logic                i_wb_we,
   input wire logic [7:0]          i_wb_adr,
   input wire logic                o_wb_ack,
   input wire drs_pkg::drs_disk_t  i_disk,
   input wire logic                i_transfer_end,
   input wire logic [1:0]          o_unit,
   input wire logic                o_dma_req,
   input wire logic                o_irq
);
   logic [15:0] held;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   // age of a pending request; a fresh byte restarts it
   always_ff @(posedge i_ref_clk) begin
      if (i_reset || !o_dma_req || i_disk.byte_valid)
         held <= 16'h0;
      else
         held <= held + 16'h1;
   end
   a_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("ack late");
   a_ack_once: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held");
   a_req_cause: assert property ($rose(o_dma_req) |-> $past(i_disk.byte_valid))
      else $error("request without byte");
   a_req_retire: assert property (o_wb_ack && !i_wb_we && i_wb_adr == REG_DATA
      && !i_disk.byte_valid |=> !o_dma_req) else $error("request not retired");
   a_crc_stop: assert property (i_disk.crc_valid && !i_disk.byte_valid
      |=> !o_dma_req) else $error("request past crc");
   a_overrun_cap: assert property (held <= OVR_LONG_CYC + 2)
      else $error("request outlived overrun");
   a_end_quiet: assert property (i_transfer_end [*4] |-> !$rose(o_dma_req))
      else $error("request after transfer end");
   a_unit_hold: assert property (o_dma_req |-> $stable(o_unit))
      else $error("unit moved in transfer");
   a_result_done: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
      && !i_wb_we && i_wb_adr == REG_RESULT && o_irq |=> !o_irq)
      else $error("irq after result");
   c_req: cover property ($rose(o_dma_req));
   c_end: cover property ($fell(o_irq));
   c_tend: cover property (i_transfer_end && o_dma_req);
endmodule
bind drs_read_seq drs_read_seq_props #(.OVR_LONG_CYC(OVR_LONG_CYC)) props_u (
   .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
   .o_wb_ack(o_wb_ack), .i_disk(i_disk), .i_transfer_end(i_transfer_end),
   .o_unit(o_unit), .o_dma_req(o_dma_req), .o_irq(o_irq));
`default_nettype wire

// File: drs_drive_model.sv
// behavioural drive: one id per command, then mark, data bytes and crc except in mode 1
`timescale 1ns/100ps
`default_nettype none
module drs_drive_model
   import drs_pkg::*;
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_go,
   input  wire logic [1:0] i_mode,
   input  wire drs_id_t    i_id,
   input  wire logic [7:0] i_base,
   input  wire logic [3:0] i_count,
   output drs_disk_t       o_disk,
   output logic            o_ready
);
   drs_disk_t d;
   // idle data lines show the inverse, never the stale byte
   task automatic pulse(input drs_disk_t v);
      drs_disk_t q;
      q = '0;
      q.data = ~v.data;
      // gap comes first so the model is back watching go at once
      repeat (40) @(posedge i_ref_clk);
      o_disk <= v;
      @(posedge i_ref_clk);
      o_disk <= q;
   endtask
   initial begin
      o_disk = '0;
      o_ready = 1'b1;
      forever begin
         @(posedge i_go);
         repeat (700) @(posedge i_ref_clk);
         d = '0; d.id_valid = 1'b1; d.id = i_id;
         d.id_crc_ok = (i_mode != 2'd1);
         pulse(d);
         if (i_mode != 2'd1) begin
            d = '0; d.mark_valid = 1'b1;
            d.mark = (i_mode == 2'd3) ? DELETED_MARK : DATA_MARK;
            pulse(d);
            for (int i = 0; i < i_count; i++) begin
               d = '0; d.byte_valid = 1'b1; d.data = i_base + 8'(i);
               pulse(d);
            end
            d = '0; d.crc_valid = 1'b1; d.crc_ok = (i_mode != 2'd2);
            pulse(d);
         end
      end
   end
endmodule
`default_nettype wire

// File: drs_read_seq_test.sv
// self-checking bench for the read data sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a,e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
 $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module drs_read_seq_test;
   import drs_pkg::*;
   logic        clk, rst, cyc, stb, we, go, tend, ack, dma_request_output, irq, hload, rdy;
   logic [7:0]  adr, base;
   logic [31:0] wdat, rdat, rd;
   logic [1:0]  unit, mode, ounit;
   logic [3:0]  cnt;
   logic [7:0]  q[$];
   logic        ab, idx;
   drs_id_t     id;
   drs_disk_t   disk;
   int          fail_count = 0, samples_checked = 0, cyc_n = 0, n;
   drs_read_seq #(.MARK_WAIT_CYC(200), .HT_UNIT(10)) dut_u (
      .i_ref_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_disk(disk), .i_index(idx),
      .i_ready(rdy), .i_drive_size(1'b0), .i_transfer_end(tend),
      .o_unit(ounit), .o_head_sel(), .o_head_load(hload),
      .o_dma_req(dma_request_output), .o_irq(irq));
   drs_drive_model drive_u (.i_ref_clk(clk), .i_go(go), .i_mode(mode),
      .i_id(id), .i_base(base), .i_count(cnt), .o_disk(disk), .o_ready(rdy));
   task automatic conclude;
      $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // classic cycle: hold until ack is sampled, then release
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 0; stb <= 0;
   endtask
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n == 40000) begin
         fail_count++;
         conclude();
      end
   end
   initial begin
      rst = 1; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; go = 0;
      tend = 0; mode = 0; id = '0; base = 0; cnt = 0; idx = 0;
      n = $urandom(32'h12b863ec);
      repeat (8) @(posedge clk);
      rst <= 0;
      wb(0, 8'h3c, 0); `CHK(rd, 32'h0)
      wb(1, REG_LIMIT, 32'h0102_0009); // unload 1, load 2, end sector 9
      for (int k = 0; k < 8; k++) begin
         mode = 2'(k); unit = 2'($urandom); base = 8'($urandom);
         cnt = 4'(2 + $urandom % 6);
         id = '{8'($urandom % 200), 8'h00, 8'(1 + $urandom % 7), 8'h01};
         ab = (mode == 2'd1 || mode == 2'd2);
         for (int j = 0; j < cnt; j++) q.push_back(base + 8'(j));
         wb(1, REG_PARAM, id);
         wb(1, REG_CTRL, {29'h0, unit, 1'b1});
         go <= 1;
         @(posedge clk);
         go <= 0;
         @(posedge clk);
         `CHK(ounit, unit)
         n = 0;
         while (irq !== 1'b1) begin
            @(posedge clk);
            if (dma_request_output === 1'b1) begin
               `CHK(hload, 1'b1)
               if (n == cnt - 1) tend <= 1;
               wb(0, REG_DATA, 0);
               `CHK(rd[7:0], q.pop_front())
               n++;
            end
         end
         tend <= 0;
         `CHK(q.size(), (mode == 2'd1) ? int'(cnt) : 0)
         q.delete();
         wb(0, REG_STATUS, 0);
         `CHK({rd[24], rd[23:8], rd[7:3]}, {1'b1, (mode == 2'd2) ? 8'h20 : (mode == 2'd3) ? 8'h40 : 8'h00, ab ? 8'h20 : 8'h00, ab ? 5'h08 : 5'h00})
         wb(0, REG_RESULT, 0);
         if (!ab) `CHK(rd, {id.cyl, id.head, id.sec + 8'h1, id.len})
         wb(0, REG_STATUS, 0);
         `CHK({rd[25:24], irq}, 3'b100)
      end
      // no address mark at all: three index pulses end the search
      wb(1, REG_CTRL, 32'h1);
      repeat (3) begin
         repeat (400) @(posedge clk);
         idx <= 1;
         @(posedge clk);
         idx <= 0;
      end
      repeat (8) @(posedge clk);
      wb(0, REG_STATUS, 0);
      `CHK(rd[23:0], 24'h00_0140)
      wb(0, REG_RESULT, 0);
      conclude();
   end
endmodule
`default_nettype wire
